// ==== hdl/ptss_pkg.sv ====
// Shared constants and types of the heartbeat-aligned time supervisor.
package ptss_pkg;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned TICK_MS = 5;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned TICK_LEAD_US = 100;
    localparam int unsigned TICK_LEAD_CYC = (CLK_HZ / 1_000_000) * TICK_LEAD_US;
    localparam logic [7:0] TICKS_PER_S = 8'hc8;
    localparam logic [31:0] ONE_SECOND = 32'h1;
    localparam logic [1:0] SLIP_LIMIT = 2'h3;
    localparam logic [1:0] RESET_LIMIT = 2'h2;
    localparam logic [7:0] EVT_TYPE = 8'h02;
    localparam logic [15:0] EVT_CLOCK_CHANGED = 16'h0009;
    localparam logic [7:0] ERR_TYPE = 8'h03;
    localparam logic [15:0] ERR_CLOCK_UNSTABLE = 16'h0011;
    localparam logic [8:0] SAMPLES_LAST = 9'h0ff;
    localparam int unsigned LOOK_TICKS = 4;
    localparam int unsigned SST_LEAD_S = 1;
    localparam int unsigned SAMPLE_W = 16;
    typedef enum logic [0:0] {
        DS_IDLE = 1'b0,
        DS_XFER = 1'b1
    } ptss_dstate_t;
endpackage

// ==== hdl/ptss_tick_if.sv ====
// Tick bundle between the timing generator and the supervisor.
`timescale 1ns/1ns
`default_nettype none
interface ptss_tick_if;
    logic pps_rise;
    logic tick;
    logic golden;
    logic r_pulse;
    logic [7:0] idx;
    modport gen(input pps_rise, output tick, golden, r_pulse, idx);
    modport sup(output pps_rise, input tick, golden, r_pulse, idx);
endinterface
`default_nettype wire

// ==== hdl/ptss_tick_gen.sv ====
// Timing generator: one frame of 5 ms ticks per heartbeat pulse.
`timescale 1ns/1ns
`default_nettype none
module ptss_tick_gen #(
    parameter int unsigned TICK_CYC = ptss_pkg::TICK_CYC,
    parameter int unsigned TICK_LEAD = ptss_pkg::TICK_LEAD_CYC
) (
    input wire logic clock,
    input wire logic rst,
    ptss_tick_if.gen tif
);
    import ptss_pkg::*;

    localparam int CW = $clog2(TICK_CYC + 1);

    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [7:0] idx_r, idx_nxt;
    logic run_r, run_nxt;
    logic tick_r, tick_nxt;
    logic gold_r, gold_nxt;
    logic rp_r, rp_nxt;
    logic wrap;
    logic [CW:0] gap_r;

    assign wrap = run_r && cnt_r == CW'(TICK_CYC - 1);

    always_comb begin
        cnt_nxt = cnt_r;
        idx_nxt = idx_r;
        run_nxt = run_r;
        tick_nxt = 1'b0;
        gold_nxt = 1'b0;
        // The tick leads its reference pulse so setup can finish first.
        // A restart drops a pulse that would land on the new golden tick.
        rp_nxt = run_r && cnt_r == CW'(TICK_LEAD)
            && !tif.pps_rise;
        if (tif.pps_rise) begin
            // A heartbeat restarts the frame even if the last one overran.
            run_nxt = 1'b1;
            cnt_nxt = '0;
            idx_nxt = '0;
            tick_nxt = 1'b1;
            gold_nxt = 1'b1;
        end else if (wrap) begin
            cnt_nxt = '0;
            if (idx_r == TICKS_PER_S - 8'h01) begin
                run_nxt = 1'b0;
            end else begin
                idx_nxt = idx_r + 8'h01;
                tick_nxt = 1'b1;
            end
        end else if (run_r) begin
            cnt_nxt = cnt_r + CW'(1);
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
            idx_r <= '0;
            run_r <= 1'b0;
            tick_r <= 1'b0;
            gold_r <= 1'b0;
            rp_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            idx_r <= idx_nxt;
            run_r <= run_nxt;
            tick_r <= tick_nxt;
            gold_r <= gold_nxt;
            rp_r <= rp_nxt;
        end
    end

    assign tif.tick = tick_r;
    assign tif.golden = gold_r;
    assign tif.r_pulse = rp_r;
    assign tif.idx = idx_r;

    // Cycles since the last tick, read only by the checks below.
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gap_r <= '0;
        end else if (tick_r) begin
            gap_r <= (CW + 1)'(1);
        end else if (!(&gap_r)) begin
            gap_r <= gap_r + (CW + 1)'(1);
        end
    end

    sequence s_heartbeat;
        tif.pps_rise;
    endsequence

    a_tick_spacing:
        assert property (@(posedge clock) disable iff (rst)
            tick_r && !gold_r |-> gap_r == (CW + 1)'(TICK_CYC))
        else $error("tick spacing is not one tick period");

    a_frame_start:
        assert property (@(posedge clock) disable iff (rst)
            s_heartbeat |=> gold_r && tick_r && idx_r == 8'h00)
        else $error("heartbeat did not start a frame");

    a_tick_ahead:
        assert property (@(posedge clock) disable iff (rst)
            rp_r |-> gap_r == (CW + 1)'(TICK_LEAD + 1) && !tick_r)
        else $error("reference pulse not after its tick lead");
endmodule
`default_nettype wire

// ==== hdl/ptss_supervisor.sv ====
// Heartbeat-aligned time supervisor: clock check, measurement, data, start.
`timescale 1ns/1ns
`default_nettype none
module ptss_supervisor #(
    parameter int unsigned TICK_CYC = ptss_pkg::TICK_CYC,
    parameter int unsigned LOOK_TICKS = ptss_pkg::LOOK_TICKS,
    parameter int unsigned SST_LEAD_S = ptss_pkg::SST_LEAD_S
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic pps_pin,
    input wire logic data_irq_pin,
    input wire logic pm_valid,
    input wire logic [31:0] pm_stamp,
    input wire logic meas_start,
    input wire logic [7:0] meas_looks,
    input wire logic [ptss_pkg::SAMPLE_W-1:0] fifo_data,
    input wire logic pkt_ready,
    input wire logic sst_valid,
    input wire logic [31:0] sst_time,
    input wire logic [7:0] sst_sched,
    input wire logic msg_ready,
    output logic tick,
    output logic golden_tick,
    output logic r_pulse,
    output logic [31:0] local_time,
    output logic clock_set,
    output logic meas_busy,
    output logic look_setup,
    output logic txrx_en,
    output logic fifo_rd,
    output logic pkt_valid,
    output logic [ptss_pkg::SAMPLE_W-1:0] pkt_data,
    output logic pkt_last,
    output logic sst_pop,
    output logic sched_start,
    output logic [7:0] sched_num,
    output logic msg_valid,
    output logic [7:0] msg_type,
    output logic [15:0] msg_id
);
    import ptss_pkg::*;

    ptss_tick_if tif ();

    ptss_tick_gen #(
        .TICK_CYC(TICK_CYC),
        .TICK_LEAD(TICK_LEAD_CYC)
    ) u_tick_gen (
        .clock(clock),
        .rst(rst),
        .tif(tif)
    );

    // Pin synchronisers; edge detection looks only at the second stage on.
    logic pps_s1_r, pps_s2_r, pps_s3_r;
    logic irq_s1_r, irq_s2_r, irq_s3_r;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            {pps_s1_r, pps_s2_r, pps_s3_r} <= 3'h0;
            {irq_s1_r, irq_s2_r, irq_s3_r} <= 3'h0;
        end else begin
            {pps_s1_r, pps_s2_r, pps_s3_r} <= {pps_pin, pps_s1_r, pps_s2_r};
            {irq_s1_r, irq_s2_r, irq_s3_r} <= {data_irq_pin, irq_s1_r, irq_s2_r};
        end
    end
    assign tif.pps_rise = pps_s2_r && !pps_s3_r;

    // Time keeping and the golden-tick check.
    logic [31:0] local_r, local_nxt, stamp_r, stamp_nxt;
    logic [7:0] age_r, age_nxt;
    logic have_r, have_nxt, set_r, set_nxt;
    logic [1:0] slip_r, slip_nxt, resets_r, resets_nxt;
    logic evt_r, evt_nxt, err_r, err_nxt;
    logic young, check, slip1, exact;
    logic [31:0] expect_w, adv_w, diff_w;

    // A message counts as fresh for one second of ticks after arrival.
    assign young = have_r && age_r < TICKS_PER_S;
    assign check = tif.golden && !meas_busy && young;
    assign expect_w = stamp_r + ONE_SECOND;
    assign adv_w = local_r + ONE_SECOND;
    assign diff_w = expect_w - adv_w;
    assign exact = diff_w == 32'h0;
    assign slip1 = diff_w == ONE_SECOND || diff_w == ~32'h0;

    always_comb begin
        local_nxt = local_r;
        stamp_nxt = stamp_r;
        age_nxt = age_r;
        have_nxt = have_r;
        set_nxt = 1'b0;
        slip_nxt = slip_r;
        resets_nxt = resets_r;
        // A new message stands; set wins over the send that clears it.
        evt_nxt = evt_r && !msg_ready;
        err_nxt = err_r && !(msg_ready && !evt_r);
        if (pm_valid) begin
            stamp_nxt = pm_stamp;
            age_nxt = 8'h00;
            have_nxt = 1'b1;
        end else if (tif.tick && age_r < TICKS_PER_S) begin
            age_nxt = age_r + 8'h01;
        end
        if (tif.golden) begin
            local_nxt = adv_w;
            if (check) begin
                if (exact) begin
                    slip_nxt = 2'h0;
                    resets_nxt = 2'h0;
                end else if (slip1 && slip_r < SLIP_LIMIT) begin
                    slip_nxt = slip_r + 2'h1;
                end else begin
                    local_nxt = expect_w;
                    set_nxt = 1'b1;
                    evt_nxt = 1'b1;
                    slip_nxt = 2'h0;
                    if (resets_r != 2'h3) begin
                        resets_nxt = resets_r + 2'h1;
                    end
                    if (!slip1 || resets_r >= RESET_LIMIT - 2'h1) begin
                        err_nxt = 1'b1;
                    end
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            local_r <= 32'h0;
            stamp_r <= 32'h0;
            age_r <= 8'h00;
            have_r <= 1'b0;
            set_r <= 1'b0;
            slip_r <= 2'h0;
            resets_r <= 2'h0;
            evt_r <= 1'b0;
            err_r <= 1'b0;
        end else begin
            local_r <= local_nxt;
            stamp_r <= stamp_nxt;
            age_r <= age_nxt;
            have_r <= have_nxt;
            set_r <= set_nxt;
            slip_r <= slip_nxt;
            resets_r <= resets_nxt;
            evt_r <= evt_nxt;
            err_r <= err_nxt;
        end
    end

    // The event goes out before the error when both are pending.
    assign msg_valid = evt_r || err_r;
    assign msg_type = evt_r ? EVT_TYPE : ERR_TYPE;
    assign msg_id = evt_r ? EVT_CLOCK_CHANGED : ERR_CLOCK_UNSTABLE;

    // Measurement progression, paced by ticks only.
    logic busy_r, busy_nxt, setup_r, setup_nxt, txrx_r, txrx_nxt;
    logic [7:0] looks_r, looks_nxt, lt_r, lt_nxt;

    always_comb begin
        busy_nxt = busy_r;
        looks_nxt = looks_r;
        lt_nxt = lt_r;
        setup_nxt = 1'b0;
        txrx_nxt = txrx_r;
        if (!busy_r && meas_start && meas_looks != 8'h00) begin
            busy_nxt = 1'b1;
            looks_nxt = meas_looks;
            lt_nxt = 8'h00;
        end else if (busy_r && tif.tick) begin
            setup_nxt = lt_r == 8'h00;
            txrx_nxt = lt_r != 8'h00;
            if (lt_r == 8'(LOOK_TICKS - 1)) begin
                lt_nxt = 8'h00;
                if (looks_r == 8'h01) begin
                    busy_nxt = 1'b0;
                    txrx_nxt = 1'b0;
                end else begin
                    looks_nxt = looks_r - 8'h01;
                end
            end else begin
                lt_nxt = lt_r + 8'h01;
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            busy_r <= 1'b0;
            looks_r <= 8'h00;
            lt_r <= 8'h00;
            setup_r <= 1'b0;
            txrx_r <= 1'b0;
        end else begin
            busy_r <= busy_nxt;
            looks_r <= looks_nxt;
            lt_r <= lt_nxt;
            setup_r <= setup_nxt;
            txrx_r <= txrx_nxt;
        end
    end

    // Data burst: one interrupt moves one full block of samples.
    ptss_dstate_t ds_r, ds_nxt;
    logic [8:0] cnt_r, cnt_nxt;
    logic irq_pend_r, irq_pend_nxt, pop;
    logic pv_r, pv_nxt, pl_r, pl_nxt;
    logic [SAMPLE_W-1:0] pd_r, pd_nxt;

    assign pop = ds_r == DS_XFER && (!pv_r || pkt_ready);
    assign fifo_rd = pop;

    always_comb begin
        ds_nxt = ds_r;
        cnt_nxt = cnt_r;
        // An interrupt during a burst is held, not lost.
        irq_pend_nxt = irq_pend_r || (irq_s2_r && !irq_s3_r);
        pv_nxt = pop || (pv_r && !pkt_ready);
        pd_nxt = pop ? fifo_data : pd_r;
        pl_nxt = pop ? cnt_r == SAMPLES_LAST : pl_r;
        unique case (ds_r)
            DS_IDLE: begin
                if (irq_pend_r) begin
                    irq_pend_nxt = irq_s2_r && !irq_s3_r;
                    ds_nxt = DS_XFER;
                    cnt_nxt = 9'h000;
                end
            end
            DS_XFER: begin
                if (pop) begin
                    cnt_nxt = cnt_r + 9'h001;
                    if (cnt_r == SAMPLES_LAST) begin
                        ds_nxt = DS_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ds_r <= DS_IDLE;
            cnt_r <= 9'h000;
            irq_pend_r <= 1'b0;
            pv_r <= 1'b0;
            pd_r <= '0;
            pl_r <= 1'b0;
        end else begin
            ds_r <= ds_nxt;
            cnt_r <= cnt_nxt;
            irq_pend_r <= irq_pend_nxt;
            pv_r <= pv_nxt;
            pd_r <= pd_nxt;
            pl_r <= pl_nxt;
        end
    end

    // Schedule start: matched one lead ahead, on the golden tick.
    logic start_r, start_nxt;
    logic [7:0] num_r, num_nxt;

    always_comb begin
        start_nxt = tif.golden && sst_valid
            && sst_time == local_nxt + 32'(SST_LEAD_S);
        num_nxt = start_nxt ? sst_sched : num_r;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            start_r <= 1'b0;
            num_r <= 8'h00;
        end else begin
            start_r <= start_nxt;
            num_r <= num_nxt;
        end
    end

    assign tick = tif.tick;
    assign golden_tick = tif.golden;
    assign r_pulse = tif.r_pulse;
    assign local_time = local_r;
    assign clock_set = set_r;
    assign meas_busy = busy_r;
    assign look_setup = setup_r;
    assign txrx_en = txrx_r;
    assign pkt_valid = pv_r;
    assign pkt_data = pd_r;
    assign pkt_last = pl_r;
    assign sst_pop = start_r;
    assign sched_start = start_r;
    assign sched_num = num_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_slip_seen;
        check && slip1 && slip_r < SLIP_LIMIT;
    endsequence

    a_check_gate:
        assert property (set_r |-> $past(tif.golden && !busy_r && young))
        else $error("clock loaded outside a valid check");
    a_clock_load:
        assert property (check && !exact && !(slip1 && slip_r < SLIP_LIMIT)
            |=> local_r == $past(expect_w) && set_r)
        else $error("clock not loaded with stamp plus one");
    a_slip_hold:
        assert property (s_slip_seen |=> !set_r && local_r == $past(adv_w))
        else $error("tolerated slip changed the clock");
    a_event_emit:
        assert property (set_r |-> evt_r && msg_valid
            && msg_type == EVT_TYPE && msg_id == EVT_CLOCK_CHANGED)
        else $error("clock change without event message");
    a_error_big:
        assert property (check && !exact && !slip1 |=> err_r)
        else $error("large mismatch without error message");
    a_meas_ticks:
        assert property ($rose(setup_r) || $rose(txrx_r) |-> $past(tif.tick))
        else $error("measurement stepped without a tick");
    a_burst_len:
        assert property (pop && cnt_r == SAMPLES_LAST
            |=> ds_r == DS_IDLE && pv_r && pl_r)
        else $error("burst did not end after the last sample");
    a_sst_hand:
        assert property (start_r |-> num_r == $past(sst_sched)
            && $past(tif.golden))
        else $error("schedule handed over with wrong number");
    a_slip_clear:
        assert property (check && exact |=> slip_r == 2'h0 ##1 !set_r)
        else $error("slip count not cleared on a clean check");
endmodule
`default_nettype wire

// ==== dv/ptss_partner.sv ====
// Heartbeat, periodic-message and preprocessor FIFO model.
`timescale 1ns/1ns
`default_nettype none
module ptss_partner (
    input wire logic clock,
    input wire logic fifo_rd,
    output logic pps_pin,
    output logic pm_valid,
    output logic [31:0] pm_stamp,
    output logic [15:0] fifo_data,
    output logic [15:0] pops
);
    logic [31:0] last_stamp;
    initial begin
        pps_pin = 1'b0;
        pm_valid = 1'b0;
        last_stamp = 32'h0;
        pops = 16'h0;
    end
    // Outside its strobe each bus shows the inverse, so a late sample fails.
    assign pm_stamp = pm_valid ? last_stamp : ~last_stamp;
    assign fifo_data = fifo_rd ? pops : ~pops;
    always @(posedge clock) begin
        if (fifo_rd) begin
            pops <= pops + 16'h1;
        end
    end
    // A stamped message just before its heartbeat, on the whole second.
    task automatic second(input logic [31:0] stamp);
        @(posedge clock);
        #2;
        last_stamp = stamp;
        pm_valid = 1'b1;
        @(posedge clock);
        #2;
        pm_valid = 1'b0;
        pps_pin = 1'b1;
        repeat (2) @(posedge clock);
        #2;
        pps_pin = 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Self-checking bench for the heartbeat-aligned time supervisor.
`timescale 1ns/1ns
`default_nettype none
module tb;
    import ptss_pkg::*;
    localparam int unsigned TCYC = 2600;
    logic clock, rst, pps_pin, pm_valid, data_irq_pin, meas_start;
    logic pkt_ready, sst_valid, msg_ready, tick, golden_tick, r_pulse;
    logic clock_set, meas_busy, look_setup, txrx_en, fifo_rd, pkt_valid;
    logic pkt_last, sst_pop, sched_start, msg_valid;
    logic [31:0] pm_stamp, sst_time, local_time, lt;
    logic [7:0] meas_looks, sst_sched, sched_num, msg_type;
    logic [15:0] fifo_data, pkt_data, msg_id, pops;
    int mismatches, check_count, slip, rcnt;
    logic busy_m;

    ptss_supervisor #(.TICK_CYC(TCYC)) ptss_supervisor_i (
        .clock, .rst, .pps_pin, .data_irq_pin, .pm_valid, .pm_stamp,
        .meas_start, .meas_looks, .fifo_data, .pkt_ready, .sst_valid,
        .sst_time, .sst_sched, .msg_ready, .tick, .golden_tick, .r_pulse,
        .local_time, .clock_set, .meas_busy, .look_setup, .txrx_en,
        .fifo_rd, .pkt_valid, .pkt_data, .pkt_last, .sst_pop,
        .sched_start, .sched_num, .msg_valid, .msg_type, .msg_id
    );
    ptss_partner ptss_partner_i (
        .clock, .fifo_rd, .pps_pin, .pm_valid, .pm_stamp, .fifo_data, .pops
    );

    always #20 clock = ~clock;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic take_msg(input logic [7:0] ty, input logic [15:0] id);
        int n;
        n = 0;
        while (msg_valid !== 1'b1 && n < 10) begin
            @(negedge clock);
            n++;
        end
        chk(msg_valid, 1'b1);
        chk(msg_type, ty);
        chk(msg_id, id);
        @(posedge clock);
        #2 msg_ready = 1'b1;
        @(posedge clock);
        #2 msg_ready = 1'b0;
        @(negedge clock);
    endtask

    // Sends one second and checks the clock against the expected outcome.
    task automatic hb(input logic [31:0] stamp);
        logic [31:0] d;
        logic set, errx;
        int n;
        d = lt - stamp;
        set = 1'b0;
        errx = 1'b0;
        if (busy_m || d == 32'h0) begin
            lt = lt + 32'h1;
            if (!busy_m) begin
                slip = 0;
                rcnt = 0;
            end
        end else if ((d == 32'h1 || d == 32'hffffffff) && slip < 3) begin
            slip++;
            lt = lt + 32'h1;
        end else begin
            set = 1'b1;
            errx = !(d == 32'h1 || d == 32'hffffffff) || rcnt > 0;
            rcnt++;
            slip = 0;
            lt = stamp + 32'h1;
        end
        ptss_partner_i.second(stamp);
        n = 0;
        while (golden_tick !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        chk(n < 20, 1'b1);
        @(negedge clock);
        chk(local_time, lt);
        chk(clock_set, set);
        chk(msg_valid, set);
        if (set) begin
            take_msg(EVT_TYPE, EVT_CLOCK_CHANGED);
            if (errx) begin
                take_msg(ERR_TYPE, ERR_CLOCK_UNSTABLE);
            end
            chk(msg_valid, 1'b0);
        end
    endtask

    task automatic time_check();
        int offs[15] = '{0, 1, -1, 1, 0, -1, -1, 1, 1, 1, 64, 1, 1, 1, 1};
        hb(32'h100);
        foreach (offs[i]) begin
            hb(lt + 32'(offs[i]));
        end
    endtask

    task automatic tick_timing();
        int n, rp;
        hb(lt);
        n = 1;
        rp = 0;
        while (tick !== 1'b1 && n < TCYC + 10) begin
            if (r_pulse === 1'b1 && rp == 0) begin
                rp = n;
            end
            @(negedge clock);
            n++;
        end
        chk(rp, TICK_LEAD_CYC + 1);
        chk(n, TCYC);
        chk(golden_tick, 1'b0);
    endtask

    task automatic measure();
        int k, n;
        @(posedge clock);
        #2 meas_looks = 8'h2;
        meas_start = 1'b1;
        @(posedge clock);
        #2 meas_start = 1'b0;
        @(negedge clock);
        chk(meas_busy, 1'b1);
        busy_m = 1'b1;
        hb(lt + 32'h5);
        for (k = 0; k < 2 * LOOK_TICKS; k++) begin
            if (k > 0) begin
                n = 0;
                while (tick !== 1'b1 && n < TCYC + 10) begin
                    @(negedge clock);
                    n++;
                end
                @(negedge clock);
            end
            chk(look_setup, k % LOOK_TICKS == 0);
            chk(txrx_en, k % LOOK_TICKS != 0
                && k < 2 * LOOK_TICKS - 1);
            chk(meas_busy, k < 2 * LOOK_TICKS - 1);
        end
        busy_m = 1'b0;
    endtask

    // Two interrupts, the second inside the first burst, sink stalling.
    task automatic burst();
        int k, n;
        k = 0;
        n = 0;
        while (k < 512 && n < 3000) begin
            @(posedge clock);
            #2 pkt_ready = (n % 3 != 0);
            data_irq_pin = (n < 3) || (n >= 100 && n < 104);
            @(negedge clock);
            if (pkt_valid === 1'b1 && pkt_ready) begin
                chk(pkt_data, 16'(k));
                chk(pkt_last, k[7:0] == 8'hff);
                k++;
            end
            n++;
        end
        repeat (20) @(negedge clock);
        chk(pkt_valid, 1'b0);
        chk(pops, 16'h200);
    endtask

    task automatic sched();
        @(posedge clock);
        #2 sst_valid = 1'b1;
        sst_sched = 8'h5a;
        sst_time = lt + 32'h2 + SST_LEAD_S;
        hb(lt);
        chk(sched_start, 1'b0);
        @(posedge clock);
        #2 sst_time = lt + 32'h1 + SST_LEAD_S;
        hb(lt);
        chk(sched_start, 1'b1);
        chk(sst_pop, 1'b1);
        chk(sched_num, 8'h5a);
    endtask

    task automatic close_out();
        if (mismatches == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // The run needs about 22000 cycles; the limit leaves a wide margin.
    initial begin
        #(80000 * 40);
        mismatches++;
        close_out();
    end

    initial begin
        clock = 1'b0;
        rst = 1'b1;
        {data_irq_pin, meas_start, pkt_ready, sst_valid, msg_ready} = 5'h0;
        {meas_looks, sst_sched, sst_time} = 48'h0;
        mismatches = 0;
        check_count = 0;
        slip = 0;
        rcnt = 0;
        lt = 32'h0;
        busy_m = 1'b0;
        repeat (16) @(posedge clock);
        #2 rst = 1'b0;
        time_check();
        tick_timing();
        measure();
        burst();
        sched();
        close_out();
    end
endmodule
`default_nettype wire
